// [smc_pkg.sv]
// Package for the sleep mode and clock gating controller.
// Assumes an 8-bit core register port and a single 40 MHz system clock.
package smc_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam logic [7:0] SMC_DATA_OFFSET  = 8'h53;
  localparam logic [7:0] SMC_IO_BIAS      = 8'h20;
  localparam logic [7:0] SMC_IO_OFFSET    = SMC_DATA_OFFSET - SMC_IO_BIAS;
  localparam logic [7:0] SMC_PRR_OFFSET   = 8'h64;
  localparam logic [7:0] SMC_CTRL_RESET   = 8'h00;
  localparam logic [7:0] SMC_PRR_RESET    = 8'h00;
  localparam int         SMC_ARM_BIT      = 0;
  localparam int         SMC_MODE_LSB     = 1;
  localparam int         SMC_MODE_MSB     = 3;
  localparam logic [7:0] SMC_PRR_WMASK    = 8'hef;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam int         SMC_STANDBY_WAKE = 6;
  localparam int         SMC_IRQ_HOLD     = 4;
  localparam int         SMC_CNT_W        = 16;

  // ****************************************************************
  // Modes and states
  // ****************************************************************
  typedef enum logic [2:0] {
    SMC_MODE_IDLE     = 3'h0,
    SMC_MODE_ADC_NR   = 3'h1,
    SMC_MODE_PDOWN    = 3'h2,
    SMC_MODE_PSAVE    = 3'h3,
    SMC_MODE_RSVD4    = 3'h4,
    SMC_MODE_RSVD5    = 3'h5,
    SMC_MODE_STANDBY  = 3'h6,
    SMC_MODE_EXT_STBY = 3'h7
  } smc_mode_t;

  typedef enum logic [1:0] {
    SMC_ST_RUN   = 2'h0,
    SMC_ST_SLEEP = 2'h1,
    SMC_ST_START = 2'h3,
    SMC_ST_HOLD  = 2'h2
  } smc_state_t;

  // Wake-up event group coming from peripherals and pins.
  typedef struct packed {
    logic ext_reset;
    logic wdt_reset;
    logic wdt_irq;
    logic bod_reset;
    logic twi_match;
    logic ext_level;
    logic pin_change;
    logic t2_ovf;
    logic t2_cmp;
    logic adc_done;
    logic eep_ready;
    logic other_io;
  } smc_wake_t;

  // Clock and analog enables driven to the rest of the chip.
  typedef struct packed {
    logic clk_cpu_en;
    logic clk_flash_en;
    logic clk_io_en;
    logic clk_adc_en;
    logic clk_asy_en;
    logic main_osc_en;
    logic timer_osc_en;
    logic acomp_en;
    logic vref_en;
    logic bod_en;
    logic wdt_en;
    logic adc_en;
    logic in_buf_en;
  } smc_gate_t;

endpackage : smc_pkg

// [smc_sync.sv]
// Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes the destination clock is the system clock.
`timescale 1ns/1ps
`default_nettype none
module smc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_next;

  // Next values: the first stage is read only by the second.
  always_comb begin
    meta_next = ce ? d : meta_reg;
    q_next    = ce ? meta_reg : q;
  end

  // Register both stages.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end

endmodule : smc_sync
`default_nettype wire

// [smc_sleep_ctrl.sv]
// Sleep mode controller: control register, power reduction register,
// sleep sequencing, wake-up gating and clock / analog enables.
// Assumes the core bus and the sleep strobe are on clk; wake-up events
// come from pins or other domains and are synchronised; fuse levels are used unsynchronised.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (R1) Mode 010 enters power-down, oscillator stopped.
// (R2) Power-down wakes only on listed sources.
// (R3) Power-down halts all generated clocks.
// (R4) Vanished level still wakes, no interrupt.
// (R5) Power-down exit waits fuse start-up delay.
// (R6) Mode 011 power-save keeps timer2 running.
// (R7) Timer2 wakes power-save and extended standby only with enables set.
// (R8) Timer2 clocking selects which oscillators stop.
// (R9) Mode 110 standby, oscillator on, six cycles.
// (R10) Mode 111 extended standby, six cycles.
// (R11) Reduction bit stops clock, blocks access.
// (R12) Clearing reduction bit resumes frozen module.
// (R13) Reduction acts in active and idle.
// (R14) Enabled ADC stays on; restart is extended.
// (R15) Comparator off in deep modes; reference kept.
// (R16) Fused brown-out detector always active.
// (R17) Enabled watchdog keeps running always.
// (R18) Reference on only when a user needs.
// (R19) Input buffers off when io, adc stop.
// (R20) Debug fuse keeps main clock running.
// (R21) Control register at 0x53, io 0x33.
// (R22) Mode field bits 3:1, arm bit 0.
// (R23) Software arms before the sleep instruction.
// (R24) Interrupt wake holds CPU four cycles.
// (R25) Mode and arm sampled at sleep.
module smc_sleep_ctrl #(
  parameter int                      PRR_BITS      = 8,
  parameter logic [smc_pkg::SMC_CNT_W-1:0] STARTUP_CYCLES = 16'h4000
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                ce,
  // Core register port.
  input  wire logic                reg_io_space,
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  // Core sleep instruction strobe and core status.
  input  wire logic                sleep_exec,
  input  wire logic                global_irq_en,
  input  wire logic [1:0]          timer2_interrupt_mask,
  // Asynchronous wake sources and fuses / static configuration.
  input  wire smc_pkg::smc_wake_t  wake_in,
  input  wire logic                fuse_ext_crystal,
  input  wire logic                fuse_bod_on,
  input  wire logic                fuse_debug_on,
  input  wire logic                t2_async,
  input  wire logic                t2_enabled,
  input  wire logic                wdt_on,
  input  wire logic                adc_on,
  input  wire logic                acomp_on,
  input  wire logic                acomp_int_ref,
  input  wire logic [PRR_BITS-1:0] periph_access,
  // Outputs to core and peripherals.
  output logic                     cpu_halt,
  output logic                     irq_take,
  output logic                     adc_extended,
  output smc_pkg::smc_gate_t       gate,
  output logic [PRR_BITS-1:0]      periph_clk_en,
  output logic [PRR_BITS-1:0]      periph_blocked
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  localparam int WIN = $bits(smc_pkg::smc_wake_t);
  smc_pkg::smc_wake_t wake_s;
  logic [WIN-1:0]     wake_bits;

  smc_sync #(.WIDTH(WIN)) u_wake_sync (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .d      (wake_in),
    .q      (wake_bits)
  );

  // Typed view of the synchronised wake sources.
  assign wake_s = smc_pkg::smc_wake_t'(wake_bits);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0]          ctrl_reg;
  logic [7:0]          ctrl_next;
  logic [PRR_BITS-1:0] prr_reg;
  logic [PRR_BITS-1:0] prr_next;
  logic [7:0]          rdata_reg;
  logic [7:0]          rdata_next;
  logic                rvalid_reg;
  logic                rvalid_next;
  logic                hit_ctrl;
  logic                hit_prr;

  // Decode both address spaces of the control register.
  always_comb begin
    hit_ctrl = reg_io_space ? (reg_addr == smc_pkg::SMC_IO_OFFSET) :
                              (reg_addr == smc_pkg::SMC_DATA_OFFSET); // R21
    hit_prr  = !reg_io_space && (reg_addr == smc_pkg::SMC_PRR_OFFSET);
  end

  // Writes keep only implemented bits; reads answer one cycle later.
  always_comb begin
    ctrl_next   = ctrl_reg;
    prr_next    = prr_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    if (reg_wr && hit_ctrl) begin
      ctrl_next = reg_wdata & 8'h0f; // R22
    end
    if (reg_wr && hit_prr) begin
      prr_next = PRR_BITS'(reg_wdata & smc_pkg::SMC_PRR_WMASK); // R11 R12
    end
    if (reg_rd) begin
      rvalid_next = 1'b1;
      rdata_next  = hit_ctrl ? ctrl_reg :
                    hit_prr  ? 8'(prr_reg) : 8'h00;
    end
  end

  // Register file state, frozen by the clock enable.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg   <= smc_pkg::SMC_CTRL_RESET; // R22
      prr_reg    <= PRR_BITS'(smc_pkg::SMC_PRR_RESET);
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else if (ce) begin
      ctrl_reg   <= ctrl_next;
      prr_reg    <= prr_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  // ****************************************************************
  // Sleep sequencer
  // ****************************************************************
  smc_pkg::smc_state_t     state_reg;
  smc_pkg::smc_state_t     state_next;
  smc_pkg::smc_mode_t      mode_reg;
  smc_pkg::smc_mode_t      mode_next;
  logic [smc_pkg::SMC_CNT_W-1:0] cnt_reg;
  logic [smc_pkg::SMC_CNT_W-1:0] cnt_next;
  logic                    irq_wake_reg;
  logic                    irq_wake_next;
  logic                    irq_take_next;
  logic                    wake_any;
  logic                    wake_irq;
  logic                    deep;
  logic                    stby;
  logic                    mode_ok;
  logic [smc_pkg::SMC_CNT_W-1:0] start_len;

  // Wake source qualification per latched mode.
  always_comb begin
    deep = (mode_reg == smc_pkg::SMC_MODE_PDOWN) || (mode_reg == smc_pkg::SMC_MODE_PSAVE) ||
           (mode_reg == smc_pkg::SMC_MODE_STANDBY) || (mode_reg == smc_pkg::SMC_MODE_EXT_STBY);
    stby = (mode_reg == smc_pkg::SMC_MODE_STANDBY) || (mode_reg == smc_pkg::SMC_MODE_EXT_STBY);
    // Common power-down set of sources.
    wake_irq = wake_s.wdt_irq | wake_s.twi_match | wake_s.ext_level |
               wake_s.pin_change; // R2
    if ((mode_reg == smc_pkg::SMC_MODE_PSAVE) || (mode_reg == smc_pkg::SMC_MODE_EXT_STBY)) begin
      wake_irq = wake_irq | (global_irq_en &
                 ((wake_s.t2_ovf & timer2_interrupt_mask[0]) |
                  (wake_s.t2_cmp & timer2_interrupt_mask[1]))); // R6 R7
    end
    if (!deep) begin
      wake_irq = wake_irq | wake_s.t2_ovf | wake_s.t2_cmp | wake_s.adc_done |
                 wake_s.eep_ready | (wake_s.other_io & (mode_reg == smc_pkg::SMC_MODE_IDLE));
    end
    wake_any = wake_irq | wake_s.ext_reset | wake_s.wdt_reset | wake_s.bod_reset; // R2
    // Standby codes need a crystal; reserved codes never sleep.
    mode_ok = !((ctrl_reg[smc_pkg::SMC_MODE_MSB:smc_pkg::SMC_MODE_LSB] == 3'h4) ||
                (ctrl_reg[smc_pkg::SMC_MODE_MSB:smc_pkg::SMC_MODE_LSB] == 3'h5) ||
                ((ctrl_reg[smc_pkg::SMC_MODE_MSB] & ctrl_reg[smc_pkg::SMC_MODE_MSB-1]) &&
                 !fuse_ext_crystal)); // R9 R10
    start_len = stby ? smc_pkg::SMC_CNT_W'(smc_pkg::SMC_STANDBY_WAKE) :
                deep ? STARTUP_CYCLES : smc_pkg::SMC_CNT_W'(1); // R5 R9 R10
  end

  // Next state of the sleep sequencer.
  always_comb begin
    state_next    = state_reg;
    mode_next     = mode_reg;
    cnt_next      = cnt_reg;
    irq_wake_next = irq_wake_reg;
    irq_take_next = 1'b0;
    case (state_reg)
      smc_pkg::SMC_ST_RUN: begin
        if (sleep_exec && ctrl_reg[smc_pkg::SMC_ARM_BIT] && mode_ok) begin // R23
          mode_next  = smc_pkg::smc_mode_t'(ctrl_reg[smc_pkg::SMC_MODE_MSB:smc_pkg::SMC_MODE_LSB]); // R25
          state_next = smc_pkg::SMC_ST_SLEEP; // R1 R6 R9 R10
        end
      end
      smc_pkg::SMC_ST_SLEEP: begin
        if (wake_any) begin
          irq_wake_next = wake_irq;
          cnt_next      = start_len; // R5
          state_next    = smc_pkg::SMC_ST_START;
        end
      end
      smc_pkg::SMC_ST_START: begin
        if (cnt_reg > smc_pkg::SMC_CNT_W'(1)) begin
          cnt_next = cnt_reg - smc_pkg::SMC_CNT_W'(1);
        end else if (irq_wake_reg) begin
          // The level must still be present when start-up ends.
          irq_wake_next = wake_irq; // R4
          cnt_next      = smc_pkg::SMC_CNT_W'(smc_pkg::SMC_IRQ_HOLD);
          state_next    = smc_pkg::SMC_ST_HOLD; // R24
        end else begin
          state_next = smc_pkg::SMC_ST_RUN;
        end
      end
      smc_pkg::SMC_ST_HOLD: begin
        if (cnt_reg > smc_pkg::SMC_CNT_W'(1)) begin
          cnt_next = cnt_reg - smc_pkg::SMC_CNT_W'(1);
        end else begin
          irq_take_next = irq_wake_reg; // R4 R24
          irq_wake_next = 1'b0;
          state_next    = smc_pkg::SMC_ST_RUN;
        end
      end
      default: begin
        state_next = smc_pkg::SMC_ST_RUN;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= smc_pkg::SMC_ST_RUN;
      mode_reg     <= smc_pkg::SMC_MODE_IDLE;
      cnt_reg      <= '0;
      irq_wake_reg <= 1'b0;
      irq_take     <= 1'b0;
    end else if (ce) begin
      state_reg    <= state_next;
      mode_reg     <= mode_next;
      cnt_reg      <= cnt_next;
      irq_wake_reg <= irq_wake_next;
      irq_take     <= irq_take_next;
    end
  end

  // ****************************************************************
  // Clock, oscillator and analog enables
  // ****************************************************************
  smc_pkg::smc_gate_t  gate_next;
  logic [PRR_BITS-1:0] pclk_next;
  logic [PRR_BITS-1:0] blocked_next;
  logic                halt_next;
  logic                adc_ext_next;
  logic                adc_was_on_reg;
  logic                asleep;
  logic                keep_t2;

  // Enables follow the latched mode while asleep or starting up.
  always_comb begin
    asleep    = (state_reg == smc_pkg::SMC_ST_SLEEP) || (state_reg == smc_pkg::SMC_ST_START);
    keep_t2   = t2_enabled && ((mode_reg == smc_pkg::SMC_MODE_PSAVE) ||
                               (mode_reg == smc_pkg::SMC_MODE_EXT_STBY));
    halt_next = asleep || (state_reg == smc_pkg::SMC_ST_HOLD); // R24
    gate_next.clk_cpu_en   = !asleep;
    gate_next.clk_flash_en = !asleep;
    gate_next.clk_io_en    = !asleep || (mode_reg == smc_pkg::SMC_MODE_IDLE);
    gate_next.clk_adc_en   = !asleep || !deep; // R3
    gate_next.clk_asy_en   = !asleep || !deep || (keep_t2 && t2_async); // R6 R8
    gate_next.main_osc_en  = !asleep || !deep || stby || fuse_debug_on ||
                             (keep_t2 && !t2_async); // R1 R8 R9 R10 R20
    gate_next.timer_osc_en = t2_async && (!asleep || !deep || keep_t2); // R8
    gate_next.acomp_en     = acomp_on && (!asleep || !deep); // R15
    gate_next.bod_en       = fuse_bod_on; // R16
    gate_next.wdt_en       = wdt_on; // R17
    gate_next.adc_en       = adc_on; // R14
    gate_next.vref_en      = fuse_bod_on || adc_on ||
                             (acomp_on && (acomp_int_ref || !asleep || !deep)); // R15 R18
    // Wake pins keep their buffers through the peripherals themselves.
    gate_next.in_buf_en    = gate_next.clk_io_en || gate_next.clk_adc_en; // R19
    adc_ext_next = adc_extended;
    if (adc_on && !adc_was_on_reg) begin
      adc_ext_next = 1'b1; // R14
    end else if (wake_s.adc_done) begin
      adc_ext_next = 1'b0;
    end
    // Reduction gates only while the io clock would run.
    pclk_next    = gate_next.clk_io_en ? ~prr_reg : '0; // R11 R12 R13
    blocked_next = prr_reg & periph_access; // R11
  end

  // Output registers.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate           <= '0;
      periph_clk_en  <= '0;
      periph_blocked <= '0;
      cpu_halt       <= 1'b0;
      adc_extended   <= 1'b0;
      adc_was_on_reg <= 1'b0;
    end else if (ce) begin
      gate           <= gate_next;
      periph_clk_en  <= pclk_next;
      periph_blocked <= blocked_next;
      cpu_halt       <= halt_next;
      adc_extended   <= adc_ext_next;
      adc_was_on_reg <= adc_on;
    end
  end

endmodule : smc_sleep_ctrl
`default_nettype wire

// [smc_periph_model.sv]
// Peripheral model: one free-running state counter per gated module.
// Assumes periph_clk_en comes from the sleep controller on clk.
`timescale 1ns/1ps
`default_nettype none
module smc_periph_model #(
  parameter int N = 8
) (
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic [N-1:0]    periph_clk_en,
  output var  logic [N-1:0][7:0] cnt
);
  // Each counter advances only while its module clock runs, so it freezes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (periph_clk_en[i]) begin
          cnt[i] <= cnt[i] + 8'h01;
        end
      end
    end
  end
endmodule : smc_periph_model
`default_nettype wire

// [smc_sleep_ctrl_checker.sv]
// Checker for the sleep controller, bound to its top module.
// Assumes ce is high whenever a read or a sleep strobe is made.
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_ctrl_checker #(
  parameter int PRR_BITS = 8
) (
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                reg_rd,
  input wire logic                reg_rvalid,
  input wire logic                sleep_exec,
  input wire logic                cpu_halt,
  input wire logic                irq_take,
  input wire logic                fuse_bod_on,
  input wire logic                fuse_debug_on,
  input wire logic                wdt_on,
  input wire logic                adc_on,
  input wire smc_pkg::smc_gate_t  gate,
  input wire logic [PRR_BITS-1:0] periph_access,
  input wire logic [PRR_BITS-1:0] periph_blocked
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without read");
  halt_cause_a: assert property ($rose(cpu_halt) |-> $past(sleep_exec, 2))
    else $error("halt without sleep strobe");
  irq_release_a: assert property (irq_take |=> !cpu_halt)
    else $error("halt kept after interrupt");
  irq_hold_a: assert property (irq_take |-> cpu_halt && $past(cpu_halt, 4))
    else $error("interrupt hold too short");
  bod_kept_a: assert property ($past(resetn) && fuse_bod_on && $past(fuse_bod_on)
    |-> gate.bod_en)
    else $error("brown-out detector dropped");
  wdt_kept_a: assert property ($past(resetn) && wdt_on && $past(wdt_on) |-> gate.wdt_en)
    else $error("watchdog dropped");
  adc_kept_a: assert property ($past(resetn) && adc_on && $past(adc_on) |-> gate.adc_en)
    else $error("converter dropped");
  debug_osc_a: assert property ($past(resetn) && fuse_debug_on && $past(fuse_debug_on)
    |-> gate.main_osc_en)
    else $error("oscillator stopped under debug");
  buf_off_a: assert property (!gate.clk_io_en && !gate.clk_adc_en |-> !gate.in_buf_en)
    else $error("input buffers left on");
  blocked_cause_a: assert property ($past(resetn)
    |-> (periph_blocked & ~$past(periph_access)) == '0)
    else $error("block without access");

  // Main scenarios reached.
  cover property ($rose(cpu_halt));
  cover property (irq_take);
  cover property ($fell(cpu_halt) && !$past(irq_take));
endmodule : smc_sleep_ctrl_checker

bind smc_sleep_ctrl smc_sleep_ctrl_checker #(.PRR_BITS(PRR_BITS)) i_smc_sleep_ctrl_checker (
  .clk, .resetn, .reg_rd, .reg_rvalid, .sleep_exec, .cpu_halt, .irq_take, .fuse_bod_on,
  .fuse_debug_on, .wdt_on, .adc_on, .gate, .periph_access, .periph_blocked);
`default_nettype wire

// [smc_sleep_ctrl_tb.sv]
// Self-checking testbench for the sleep controller.
// Assumes a short start-up parameter of 8 cycles; ce drops in one freeze test only.
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_ctrl_tb;
  logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, io = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, reg_rdata, p_acc = 8'h00, pclk, pblk;
  logic sleep_exec = 1'b0, gie = 1'b0, xtal = 1'b1, brownout_detector = 1'b0, dbg = 1'b0, t2a = 1'b1;
  logic t2e = 1'b1, wdt = 1'b0, adc = 1'b0, acmp = 1'b1, iref = 1'b0;
  logic [1:0] t2m = 2'h0;
  logic reg_rvalid, cpu_halt, irq_take, adc_ext;
  smc_pkg::smc_wake_t wake_in = '0;
  smc_pkg::smc_gate_t gate;
  logic [7:0][7:0] pm_cnt;
  logic [7:0] exp_q[$];
  logic [7:0] d, c;
  int err_count = 0, check_count = 0, irq_n = 0, n0, t[8];

  always #12.5 clk = ~clk;

  smc_sleep_ctrl #(.PRR_BITS(8), .STARTUP_CYCLES(16'h0008)) i_smc_sleep_ctrl (
    .clk(clk), .resetn(resetn), .ce(ce), .reg_io_space(io), .reg_addr(addr), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_wdata(wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sleep_exec(sleep_exec), .global_irq_en(gie), .timer2_interrupt_mask(t2m),
    .wake_in(wake_in), .fuse_ext_crystal(xtal), .fuse_bod_on(brownout_detector), .fuse_debug_on(dbg),
    .t2_async(t2a), .t2_enabled(t2e), .wdt_on(wdt), .adc_on(adc), .acomp_on(acmp),
    .acomp_int_ref(iref), .periph_access(p_acc), .cpu_halt(cpu_halt), .irq_take(irq_take),
    .adc_extended(adc_ext), .gate(gate), .periph_clk_en(pclk), .periph_blocked(pblk));

  smc_periph_model #(.N(8)) i_smc_periph_model (
    .clk(clk), .resetn(resetn), .periph_clk_en(pclk), .cnt(pm_cnt));

  // ****************************************************************
  // Checking, bus tasks and sleep tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic final_report;
    chk("rdq", 8'(exp_q.size()), 8'h00);
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    io = s; addr = a; wdata = v; wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask : wr

  task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    io = s; addr = a; rd_s = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    rd_s = 1'b0;
  endtask : rd

  task automatic go_sleep(input logic [2:0] m, input logic arm);
    wr(1'b0, 8'h53, {4'h0, m, arm});
    @(negedge clk);
    sleep_exec = 1'b1;
    @(negedge clk);
    sleep_exec = 1'b0;
    repeat (3) @(negedge clk);
  endtask : go_sleep

  // Raises one wake source until the core is released; counts the cycles.
  task automatic wake(input int b, output int n);
    n = 0;
    wake_in[b] = 1'b1;
    while (cpu_halt === 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    wake_in[b] = 1'b0;
  endtask : wake

  // Read data is compared against the oldest note of the reader.
  always @(negedge clk) if (reg_rvalid === 1'b1) chk("rdata", reg_rdata, exp_q.pop_front());
  always @(posedge clk) if (irq_take === 1'b1) irq_n++;

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(47045));
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    rd(1'b0, 8'h53, 8'h00);
    rd(1'b1, 8'h33, 8'h00);
    rd(1'b0, 8'h64, 8'h00);
    d = 8'($urandom);
    wr(1'b1, 8'h33, d);
    rd(1'b0, 8'h53, d & 8'h0f);
    d = 8'($urandom);
    wr(1'b0, 8'h64, d);
    rd(1'b0, 8'h64, d & 8'hef);
    wr(1'b0, 8'h64, 8'h00);
    wr(1'b0, 8'h10, 8'hff);
    rd(1'b0, 8'h10, 8'h00);
    // Every mode code: entry; then, except for codes 4 and 5, clock and analog enables and wake latency.
    for (int m = 0; m < 8; m++) begin
      iref = 1'($urandom);
      wdt = 1'($urandom);
      go_sleep(3'(m), 1'b1);
      chk("halt", cpu_halt, m != 4 && m != 5);
      if (cpu_halt === 1'b1) begin
        chk("io", gate.clk_io_en, m == 0);
        chk("cpu", {gate.clk_cpu_en, gate.clk_flash_en}, 2'h0);
        chk("adck", gate.clk_adc_en, m < 2);
        chk("asy", gate.clk_asy_en, m < 2 || m == 3 || m == 7);
        chk("osc", gate.main_osc_en, m < 2 || m > 5);
        chk("tosc", gate.timer_osc_en, m < 2 || m == 3 || m == 7);
        chk("acmp", gate.acomp_en, m < 2);
        chk("vref", gate.vref_en, m < 2 || iref);
        chk("pclk", pclk, (m == 0) ? 8'hff : 8'h00);
        chk("ibuf", gate.in_buf_en, m < 2);
        wake(5, t[m]);
      end
    end
    chk("pd_sb", 8'(t[2] - t[6]), 8'h02);
    chk("pd_ps", 8'(t[3] - t[2]), 8'h00);
    chk("es_sb", 8'(t[7] - t[6]), 8'h00);
    chk("pd_id", 8'(t[2] - t[0]), 8'h07);
    xtal = 1'b0;
    go_sleep(3'h6, 1'b1);
    chk("nox", cpu_halt, 1'b0);
    xtal = 1'b1;
    go_sleep(3'h2, 1'b0);
    chk("unarm", cpu_halt, 1'b0);
    // Power-down: only listed sources wake; resets wake with no interrupt.
    for (int b = 11; b >= 5; b--) begin
      go_sleep(3'h2, 1'b1);
      wake_in[4:0] = 5'h1f;
      wr(1'b0, 8'h53, 8'h01);
      repeat (20) @(negedge clk);
      chk("asleep", cpu_halt, 1'b1);
      chk("osc", gate.main_osc_en, 1'b0);
      wake_in[4:0] = 5'h00;
      n0 = irq_n;
      wake(b, t[0]);
      chk("woke", cpu_halt, 1'b0);
      chk("irq", 8'(irq_n - n0), (b == 11 || b == 10 || b == 8) ? 8'h00 : 8'h01);
    end
    // Vanished level: wakes, but no interrupt.
    go_sleep(3'h2, 1'b1);
    n0 = irq_n;
    wake_in.ext_level = 1'b1;
    repeat (3) @(negedge clk);
    wake_in.ext_level = 1'b0;
    wake(0, t[0]);
    chk("lvl", cpu_halt, 1'b0);
    chk("lvl_irq", 8'(irq_n - n0), 8'h00);
    // Timer2 wakes power-save only with both enables set.
    go_sleep(3'h3, 1'b1);
    gie = 1'b1;
    wake_in.t2_ovf = 1'b1;
    repeat (20) @(negedge clk);
    chk("t2m", cpu_halt, 1'b1);
    wake_in.t2_ovf = 1'b0;
    gie = 1'b0;
    t2m = 2'h3;
    wake_in.t2_cmp = 1'b1;
    repeat (20) @(negedge clk);
    chk("t2g", cpu_halt, 1'b1);
    gie = 1'b1;
    wake(3, t[0]);
    chk("t2w", cpu_halt, 1'b0);
    // Debug fuse keeps the main clock running in power-down.
    dbg = 1'b1;
    go_sleep(3'h2, 1'b1);
    chk("dbg", gate.main_osc_en, 1'b1);
    wake(5, t[0]);
    dbg = 1'b0;
    // Power reduction: freeze, block access, resume from the held state.
    wr(1'b0, 8'h64, 8'h01);
    repeat (2) @(negedge clk);
    c = pm_cnt[0];
    p_acc = 8'hff;
    repeat (10) @(negedge clk);
    chk("frz", pm_cnt[0], c);
    chk("pclk", pclk, 8'hfe);
    chk("blk", pblk, 8'h01);
    p_acc = 8'h00;
    wr(1'b0, 8'h64, 8'h00);
    repeat (2) @(negedge clk);
    chk("res", (pm_cnt[0] - c) inside {8'h01, 8'h02, 8'h03}, 1'b1);
    // Converter restart is marked extended until a conversion completes.
    adc = 1'b1;
    repeat (3) @(negedge clk);
    chk("ext", adc_ext, 1'b1);
    wake_in.adc_done = 1'b1;
    repeat (4) @(negedge clk);
    wake_in.adc_done = 1'b0;
    repeat (2) @(negedge clk);
    chk("ext0", adc_ext, 1'b0);
    // Clock enable low: a write is ignored while the state is frozen.
    ce = 1'b0;
    wr(1'b0, 8'h53, 8'h0e);
    ce = 1'b1;
    rd(1'b0, 8'h53, 8'h05);
    repeat (30) begin
      {brownout_detector, wdt, adc, dbg} = 4'($urandom);
      p_acc = 8'($urandom);
      @(negedge clk);
    end
    repeat (4) @(negedge clk);
    final_report();
  end
endmodule : smc_sleep_ctrl_tb
`default_nettype wire
